//--- hdl/dttp_beat_mem.sv
// Four-beat write data store with parity and registered read
`timescale 1ns/1ns
module dttp_beat_mem
	import dttp_pkg::*;
(
	// Clock
	input wire logic pclk,
	// Write port from the core
	input wire logic we,
	input wire logic [1:0] waddr,
	input wire logic [63:0] wdata,
	// Read port toward the bus drivers
	input wire logic [1:0] raddr,
	output logic [71:0] rdata_q
);

	logic [71:0] mem_q [4];

	// Store data with its odd parity
	always_ff @(posedge pclk) begin
		if (we) begin
			mem_q[waddr] <= {wdata, dttp_odd_par(wdata)};
		end
	end

	// Registered read
	always_ff @(posedge pclk) begin
		rdata_q <= mem_q[raddr];
	end

endmodule

//--- hdl/dttp_par_chk.sv
// Read data parity checker with registered result
`timescale 1ns/1ns
module dttp_par_chk
	import dttp_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Sample strobe, lane mask and bus values
	input wire logic check,
	input wire logic [7:0] lane_mask,
	input wire logic [63:0] data,
	input wire logic [7:0] parity,
	// Result one cycle after the strobe
	output logic err_q,
	output logic [7:0] lanes_q
);

	logic [7:0] bad;

	// Lanes whose nine bits hold an even count of ones
	assign bad = (dttp_odd_par(data) ^ parity) & lane_mask;

	// Result register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_q <= 1'b0;
			lanes_q <= 8'h00;
		end else begin
			err_q <= check & (|bad);
			lanes_q <= check ? bad : 8'h00;
		end
	end

endmodule

//--- hdl/dttp_tenure.sv
// Data tenure termination and read parity logic of the system bus
//
// What this block does
// - Check odd parity on all eight read lanes
// - Direct-store reads check only high-half lanes
// - Enabled parity error raises exception and error output
// - Error output second clock, released third
// - Drive disable floats write data next cycle
// - Drive disable ignored during reads
// - Hold write data or wait without acknowledge
// - Data retry after acknowledge discards read data
// - Read data valid only after retry negates
// - Data retry ignored during writes
// - Retry level at reset release selects mode
// - Error acknowledge ends tenure, raises exception
// - Busy flag released within one clock
// - Already delivered data never invalidated
// - Direct-store errors deferred until last tenure
// - Fast mode ignores error after read acknowledge
// - Single transfer one beat, burst four
// - Odd parity per byte including parity bit
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "dttp_cfg.svh"
module dttp_tenure
	import dttp_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Hard reset pin, active low
	input wire logic hard_reset_in_n,
	// Tenure requests from the core
	input wire logic ten_start,
	input wire dttp_ten_type ten_req,
	output logic ten_busy,
	output logic ten_done,
	// Write beat loading from the core
	input wire logic wbuf_we,
	input wire logic [1:0] wbuf_addr,
	input wire logic [63:0] wbuf_data,
	// Confirmed read data to the core
	output logic rd_valid,
	output logic [1:0] rd_beat,
	output logic [63:0] rd_data,
	// Exceptions to the core
	output logic machine_check,
	output logic checkstop,
	// Data bus, high half on top bits
	input wire logic [63:0] data_in,
	output logic [63:0] data_out,
	output logic data_oe,
	input wire logic [7:0] data_parity_lanes_in,
	output logic [7:0] data_parity_lanes_out,
	output logic data_parity_lanes_oe,
	// Termination inputs, active low
	input wire logic transfer_ack_n,
	input wire logic data_retry_n,
	input wire logic transfer_error_ack_n,
	input wire logic data_drive_disable_n,
	// Busy flag, tri-state, active low
	output logic data_bus_busy_flag_n_o,
	output logic data_bus_busy_flag_n_oe,
	// Parity error, open drain, active low
	output logic parity_error_out_n_o,
	output logic parity_error_out_n_oe
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	dttp_state_type state_q, state_d;
	dttp_ten_type req_q;
	logic [2:0] beat_q, beat_d, beats_total;
	logic pend_q, pend_d;
	logic [63:0] cap_data_q;
	logic [1:0] cap_beat_q;
	logic rd_ack_q;
	logic fast_q, hr_q;
	logic [1:0] ctrl_q;
	logic [15:0] perr_cnt_q;
	logic [7:0] perr_lanes_q;
	logic deferred_q;
	logic checkstop_q, machine_check_q;
	logic rd_valid_q, ten_done_q;
	logic [63:0] rd_data_q;
	logic [1:0] rd_beat_q;
	logic dbb_q, data_oe_q, dpe_q;
	logic [31:0] prdata_q;
	logic ta, drty, transfer_error_ack, dis;
	logic active, tea_seen, ta_ok, drop, conf, rd_cycle, wr_next;
	logic raise, defer, chk_err, par_fault;
	logic [7:0] chk_lanes;
	logic [1:0] mem_raddr;
	logic [71:0] mem_rdata;
	logic apb_wr, apb_setup;

	// Known register offset
	function automatic logic reg_hit(input logic [11:0] a);
		if (a == `DTTP_ADDR_CTRL) begin
			return 1'b1;
		end else if (a == `DTTP_ADDR_STATUS) begin
			return 1'b1;
		end else if (a == `DTTP_ADDR_PERR_CNT) begin
			return 1'b1;
		end else begin
			return 1'b0;
		end
	endfunction

	// Beat count after one acknowledge and one discard
	function automatic logic [2:0] beat_step(input logic [2:0] b, input logic up,
			input logic down);
		logic [2:0] r;
		r = b;
		if (up && !down) begin
			r = b + 3'h1;
		end else if (down && !up) begin
			r = b - 3'h1;
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Termination input qualification

	// Pins are active low
	assign ta = ~transfer_ack_n;
	assign drty = ~data_retry_n;
	assign transfer_error_ack = ~transfer_error_ack_n;
	assign dis = ~data_drive_disable_n;

	assign active = (state_q == st_data) || (state_q == st_tail);
	assign rd_cycle = active && !req_q.write;
	// Single beat or burst of four
	assign beats_total = req_q.burst ? `DTTP_BURST_BEATS : `DTTP_SINGLE_BEATS;

	// Error ack is blind the cycle after a fast read ack
	assign tea_seen = transfer_error_ack && active && !(fast_q && rd_ack_q);
	// Error ack overrides ack and retry
	assign ta_ok = ta && active && !tea_seen;
	// Retry in the cycle after a read ack drops that beat
	assign drop = pend_q && drty && !tea_seen;
	// Retry negated confirms the pending beat
	assign conf = pend_q && !drty && !tea_seen;

	////////////////////////////////////////////////////////////////////////////////
	// Beat sequencing

	// Next beat count and pending read beat
	always_comb begin
		beat_d = beat_step(beat_q, ta_ok, drop);
		pend_d = ta_ok && rd_cycle && !fast_q;
	end

	// Tenure state machine
	always_comb begin
		state_d = state_q;
		case (state_q)
			st_idle: begin
				if (ten_start) begin
					state_d = st_data;
				end
			end
			st_data, st_tail: begin
				if (tea_seen) begin
					state_d = st_idle;
				end else if (beat_d == beats_total) begin
					state_d = pend_d ? st_tail : st_idle;
				end
			end
			default: begin
				state_d = st_idle;
			end
		endcase
	end

	// State, request and beat registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= st_idle;
			req_q <= '0;
			beat_q <= 3'h0;
			pend_q <= 1'b0;
		end else if (!hard_reset_in_n) begin
			state_q <= st_idle;
			req_q <= '0;
			beat_q <= 3'h0;
			pend_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (state_q == st_idle) begin
				req_q <= ten_req;
				beat_q <= 3'h0;
				pend_q <= 1'b0;
			end else begin
				beat_q <= beat_d;
				pend_q <= pend_d;
			end
		end
	end

	// Read ack history for the fast-mode error blind cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_ack_q <= 1'b0;
		end else begin
			rd_ack_q <= ta_ok && rd_cycle;
		end
	end

	// Mode strap caught at hard reset release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hr_q <= 1'b1; // Idle level of the pin, no false release edge
			fast_q <= 1'b0;
		end else begin
			hr_q <= hard_reset_in_n;
			if (!hr_q && hard_reset_in_n) begin
				fast_q <= drty;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data path

	// Capture read beat, deliver it once final
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_data_q <= 64'h0000_0000_0000_0000;
			cap_beat_q <= 2'h0;
			rd_valid_q <= 1'b0;
			rd_data_q <= 64'h0000_0000_0000_0000;
			rd_beat_q <= 2'h0;
		end else begin
			if (ta_ok && rd_cycle) begin
				cap_data_q <= data_in;
				cap_beat_q <= beat_q[1:0];
			end
			rd_valid_q <= (ta_ok && rd_cycle && fast_q) || conf;
			if (ta_ok && rd_cycle && fast_q) begin
				rd_data_q <= data_in;
				rd_beat_q <= beat_q[1:0];
			end else if (conf) begin
				rd_data_q <= cap_data_q;
				rd_beat_q <= cap_beat_q;
			end
		end
	end

	// Parity checker, high half only on direct-store reads
	dttp_par_chk u_par_chk (
		.pclk(pclk),
		.presetn(presetn),
		.check(ta_ok && rd_cycle),
		.lane_mask(req_q.dstore ? `DTTP_LANES_HIGH : `DTTP_LANES_ALL),
		.data(data_in),
		.parity(data_parity_lanes_in),
		.err_q(chk_err),
		.lanes_q(chk_lanes)
	);

	// Error seen only when checking is enabled
	assign par_fault = chk_err && ctrl_q[`DTTP_CTRL_PAR_EN];

	// Error output pulse on the second clock after ack
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dpe_q <= 1'b0;
		end else begin
			dpe_q <= par_fault;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write data path

	// Next beat on ack, beat zero while idle
	assign mem_raddr = (state_q == st_idle) ? 2'h0 :
		(ta_ok && req_q.write) ? beat_d[1:0] : beat_q[1:0];
	assign wr_next = (state_q == st_idle) ? ten_req.write : req_q.write;

	dttp_beat_mem u_beat_mem (
		.pclk(pclk),
		.we(wbuf_we),
		.waddr(wbuf_addr),
		.wdata(wbuf_data),
		.raddr(mem_raddr),
		.rdata_q(mem_rdata)
	);

	// Drivers on for writes unless disabled last cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_oe_q <= 1'b0;
		end else begin
			data_oe_q <= (state_d == st_data) && wr_next && !dis && hard_reset_in_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Busy flag

	// Busy while beats remain, dropped the clock after error ack
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dbb_q <= 1'b0;
		end else begin
			dbb_q <= (state_d == st_data) && hard_reset_in_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Exceptions

	// Direct-store error waits for the last direct-store tenure
	assign defer = tea_seen && req_q.dstore && !req_q.dstore_last;
	assign raise = par_fault || (tea_seen && !defer) ||
		(deferred_q && active && state_d == st_idle && req_q.dstore_last);

	// Deferred error flag, set wins over its own release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deferred_q <= 1'b0;
		end else if (defer) begin
			deferred_q <= 1'b1;
		end else if (!hard_reset_in_n || (raise && active && state_d == st_idle)) begin
			deferred_q <= 1'b0;
		end
	end

	// Machine check pulse or sticky checkstop; delivered data untouched
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			machine_check_q <= 1'b0;
			checkstop_q <= 1'b0;
		end else begin
			machine_check_q <= raise && ctrl_q[`DTTP_CTRL_MCE];
			if (raise && !ctrl_q[`DTTP_CTRL_MCE]) begin
				checkstop_q <= 1'b1;
			end else if (!hard_reset_in_n) begin
				checkstop_q <= 1'b0;
			end
		end
	end

	// Tenure end pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ten_done_q <= 1'b0;
		end else begin
			ten_done_q <= active && (state_d == st_idle) && hard_reset_in_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB registers

	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pwrite && reg_hit(paddr);

	// Control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `DTTP_CTRL_RESET;
		end else if (apb_wr && paddr == `DTTP_ADDR_CTRL) begin
			ctrl_q <= pwdata[1:0];
		end
	end

	// Parity error count and last bad lanes, count wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			perr_cnt_q <= 16'h0000;
			perr_lanes_q <= 8'h00;
		end else if (par_fault) begin
			perr_cnt_q <= perr_cnt_q + 16'h0001;
			perr_lanes_q <= chk_lanes;
		end else if (apb_wr && paddr == `DTTP_ADDR_PERR_CNT) begin
			perr_cnt_q <= 16'h0000;
		end
	end

	// Read data set up during the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (apb_setup) begin
			if (paddr == `DTTP_ADDR_CTRL) begin
				prdata_q <= {30'h0000_0000, ctrl_q};
			end else if (paddr == `DTTP_ADDR_STATUS) begin
				prdata_q <= 32'h0000_0000;
				prdata_q[`DTTP_ST_FAST] <= fast_q;
				prdata_q[`DTTP_ST_CHECKSTOP] <= checkstop_q;
				prdata_q[`DTTP_ST_BUSY] <= active;
				prdata_q[`DTTP_ST_DEFERRED] <= deferred_q;
				prdata_q[`DTTP_ST_LANES_LO +: 8] <= perr_lanes_q;
			end else if (paddr == `DTTP_ADDR_PERR_CNT) begin
				prdata_q <= {16'h0000, perr_cnt_q};
			end else begin
				prdata_q <= 32'h0000_0000;
			end
		end
	end

	// Zero wait state, error on unmapped offsets
	assign pready = 1'b1;
	assign pslverr = psel && penable && !reg_hit(paddr);
	assign prdata = prdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign data_out = mem_rdata[71:8];
	assign data_parity_lanes_out = mem_rdata[7:0];
	assign data_oe = data_oe_q;
	assign data_parity_lanes_oe = data_oe_q;
	assign data_bus_busy_flag_n_o = 1'b0;
	assign data_bus_busy_flag_n_oe = dbb_q;
	assign parity_error_out_n_o = 1'b0;
	assign parity_error_out_n_oe = dpe_q;
	assign ten_busy = active;
	assign ten_done = ten_done_q;
	assign rd_valid = rd_valid_q;
	assign rd_beat = rd_beat_q;
	assign rd_data = rd_data_q;
	assign machine_check = machine_check_q;
	assign checkstop = checkstop_q;

endmodule

//--- include/dttp_cfg.svh
// Offsets, field positions, reset values and counts of the tenure block
`ifndef DTTP_CFG_SVH
`define DTTP_CFG_SVH

// Register byte offsets on the APB port
`define DTTP_ADDR_CTRL 12'h000
`define DTTP_ADDR_STATUS 12'h004
`define DTTP_ADDR_PERR_CNT 12'h008

// Control register fields and reset value
`define DTTP_CTRL_PAR_EN 0
`define DTTP_CTRL_MCE 1
`define DTTP_CTRL_RESET 2'h0

// Status register fields
`define DTTP_ST_FAST 0
`define DTTP_ST_CHECKSTOP 1
`define DTTP_ST_BUSY 2
`define DTTP_ST_DEFERRED 3
`define DTTP_ST_LANES_LO 8

// Beat counts of a tenure
`define DTTP_SINGLE_BEATS 3'h1
`define DTTP_BURST_BEATS 3'h4

// Parity lanes checked for full and direct-store reads
`define DTTP_LANES_ALL 8'hFF
`define DTTP_LANES_HIGH 8'h0F

`endif

//--- include/dttp_pkg.sv
// Types and parity function shared by the tenure block
package dttp_pkg;

	// Request for one data tenure from the core side
	typedef struct packed {
		logic write;
		logic burst;
		logic dstore;
		logic dstore_last;
	} dttp_ten_type;

	// Tenure sequencer states
	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_data = 3'b010,
		st_tail = 3'b100
	} dttp_state_type;

	// Odd parity per byte lane, lane 0 is the top byte
	function automatic logic [7:0] dttp_odd_par(input logic [63:0] d);
		logic [7:0] p;
		p = 8'h00;
		for (int i = 0; i < 8; i++) begin
			p[i] = ~^d[63 - 8 * i -: 8];
		end
		return p;
	endfunction

endpackage

//--- tb/dttp_bus_model.sv
// Behavioural bus controller answering the tenure block's beats
`timescale 1ns/1ns
module dttp_bus_model
	import dttp_pkg::*;
(
	// Clock
	input wire logic pclk,
	// Request from the bench
	input wire logic go,
	input wire logic burst,
	input wire logic [7:0] bad,
	input wire logic rtry,
	input wire logic transfer_error_ack,
	input wire logic strap,
	output logic mb,
	// Termination and read data toward the block
	output logic ack_n,
	output logic retry_n,
	output logic tea_n,
	output logic [63:0] din,
	output logic [7:0] pin
);
	logic rq;
	logic rtd;
	// Odd parity per lane, lane 0 on the top byte
	function automatic logic [7:0] lp(input logic [63:0] d);
		logic [7:0] p;
		for (int i = 0; i < 8; i++) begin
			p[i] = ~^8'(d >> (56 - 8 * i));
		end
		return p;
	endfunction
	initial begin
		ack_n = 1'b1;
		rq = 1'b1;
		tea_n = 1'b1;
		mb = 1'b0;
		din = 64'h0;
		pin = 8'h0;
	end
	// Retry level at hard reset release picks the mode
	assign retry_n = rq & ~strap;
	// One acknowledge per beat after two wait states
	always @(posedge pclk) begin
		if (go) begin
			mb <= 1'b1;
			rtd = 1'b0;
			for (int b = 0; b < (burst ? 4 : 1); b++) begin
				repeat (2) @(posedge pclk);
				ack_n <= transfer_error_ack;
				tea_n <= ~transfer_error_ack;
				din <= 64'hFEDC_BA98_7654_3210 - 64'(b);
				pin <= lp(64'hFEDC_BA98_7654_3210 - 64'(b)) ^ bad;
				@(posedge pclk);
				ack_n <= 1'b1;
				tea_n <= 1'b1;
				din <= ~din; // No stale data once released
				pin <= ~pin;
				if (transfer_error_ack) break;
				if (rtry && b == 0 && !rtd) begin
					rtd = 1'b1;
					rq <= 1'b0;
					repeat (2) @(posedge pclk);
					rq <= 1'b1;
					b--;
				end
			end
			mb <= 1'b0;
		end
	end
endmodule

//--- tb/dttp_tenure_assertions.sv
// Port level checks of the tenure block
`timescale 1ns/1ns
module dttp_tenure_chk
	import dttp_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// Core side
	input wire logic hard_reset_in_n,
	input wire logic ten_start,
	input wire logic ten_busy,
	input wire logic ten_done,
	input wire logic rd_valid,
	// Bus side
	input wire logic [63:0] data_out,
	input wire logic data_oe,
	input wire logic data_parity_lanes_oe,
	input wire logic transfer_ack_n,
	input wire logic transfer_error_ack_n,
	input wire logic data_drive_disable_n,
	input wire logic data_bus_busy_flag_n_oe,
	input wire logic parity_error_out_n_oe
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////////////
	// Tenure start and termination
	a_start_busy: assert property (ten_start && !ten_busy && hard_reset_in_n |=> data_bus_busy_flag_n_oe)
		else $error("busy flag not raised after start");
	a_tea_end: assert property (!transfer_error_ack_n && data_bus_busy_flag_n_oe |=> !data_bus_busy_flag_n_oe && ten_done)
		else $error("error acknowledge did not end tenure");
	a_rd_after_ack: assert property (rd_valid |-> !$past(transfer_ack_n) || !$past(transfer_ack_n, 2))
		else $error("read beat confirmed without acknowledge");
	a_write_hold: assert property (data_oe && transfer_ack_n |=> !data_oe || $stable(data_out))
		else $error("write data moved without acknowledge");
	////////////////////////////////////////////////////////////////////////////////
	// Parity error output timing
	a_dpe_cause: assert property (parity_error_out_n_oe |-> !$past(transfer_ack_n, 2))
		else $error("parity error not two clocks after acknowledge");
	a_dpe_release: assert property (parity_error_out_n_oe && $past(transfer_ack_n) |=> !parity_error_out_n_oe)
		else $error("parity error not released on third clock");
	////////////////////////////////////////////////////////////////////////////////
	// Drive disable, output enables and unmapped APB access
	a_data_drive_disable_float: assert property (!data_drive_disable_n && data_oe |=> !data_oe && !data_parity_lanes_oe)
		else $error("data lines still driven after disable");
	a_data_drive_disable_keep: assert property (!data_drive_disable_n && data_bus_busy_flag_n_oe && transfer_ack_n && transfer_error_ack_n |=> data_bus_busy_flag_n_oe)
		else $error("busy flag dropped under disable");
	a_oe_busy: assert property (data_oe |-> data_bus_busy_flag_n_oe && data_parity_lanes_oe)
		else $error("data driven outside tenure");
	a_apb_err: assert property (psel && penable && paddr > 12'h008 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
endmodule
bind dttp_tenure dttp_tenure_chk i_dttp_tenure_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
	.hard_reset_in_n(hard_reset_in_n), .ten_start(ten_start), .ten_busy(ten_busy),
	.ten_done(ten_done), .rd_valid(rd_valid), .data_out(data_out), .data_oe(data_oe),
	.data_parity_lanes_oe(data_parity_lanes_oe), .transfer_ack_n(transfer_ack_n),
	.transfer_error_ack_n(transfer_error_ack_n), .data_drive_disable_n(data_drive_disable_n),
	.data_bus_busy_flag_n_oe(data_bus_busy_flag_n_oe),
	.parity_error_out_n_oe(parity_error_out_n_oe));

//--- tb/dttp_tenure_tb.sv
// Self-checking bench of the tenure block
`timescale 1ns/1ns
`include "dttp_cfg.svh"
module dttp_tenure_tb
	import dttp_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic hard_reset_in_n, ten_start, ten_busy, ten_done, wbuf_we, rd_valid;
	dttp_ten_type ten_req;
	logic [1:0] wbuf_addr, rd_beat;
	logic [63:0] wbuf_data, rd_data, data_in, data_out;
	logic machine_check, checkstop, data_oe, data_parity_lanes_oe;
	logic [7:0] data_parity_lanes_in, data_parity_lanes_out, bad;
	logic transfer_ack_n, data_retry_n, transfer_error_ack_n, data_drive_disable_n;
	logic data_bus_busy_flag_n_o, data_bus_busy_flag_n_oe;
	logic parity_error_out_n_o, parity_error_out_n_oe, dpe_n;
	logic go, burst, rtry, transfer_error_ack, strap, mb, curw;
	int num_errors, checks, nrd, nmc, npe, ndone, wbk, m;
	// Open-drain error line with its pull-up
	assign dpe_n = parity_error_out_n_oe ? parity_error_out_n_o : 1'b1;
	dttp_tenure i_dttp_tenure (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hard_reset_in_n(hard_reset_in_n), .ten_start(ten_start),
		.ten_req(ten_req), .ten_busy(ten_busy), .ten_done(ten_done), .wbuf_we(wbuf_we),
		.wbuf_addr(wbuf_addr), .wbuf_data(wbuf_data), .rd_valid(rd_valid), .rd_beat(rd_beat),
		.rd_data(rd_data), .machine_check(machine_check), .checkstop(checkstop),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.data_parity_lanes_in(data_parity_lanes_in), .data_parity_lanes_out(data_parity_lanes_out),
		.data_parity_lanes_oe(data_parity_lanes_oe), .transfer_ack_n(transfer_ack_n),
		.data_retry_n(data_retry_n), .transfer_error_ack_n(transfer_error_ack_n),
		.data_drive_disable_n(data_drive_disable_n), .data_bus_busy_flag_n_o(data_bus_busy_flag_n_o),
		.data_bus_busy_flag_n_oe(data_bus_busy_flag_n_oe),
		.parity_error_out_n_o(parity_error_out_n_o), .parity_error_out_n_oe(parity_error_out_n_oe));
	dttp_bus_model i_dttp_bus_model (.pclk(pclk), .go(go), .burst(burst), .bad(bad), .rtry(rtry),
		.transfer_error_ack(transfer_error_ack), .strap(strap), .mb(mb), .ack_n(transfer_ack_n), .retry_n(data_retry_n),
		.tea_n(transfer_error_ack_n), .din(data_in), .pin(data_parity_lanes_in));
	////////////////////////////////////////////////////////////////////////////////
	// Compare, count, report
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t saw %h want %h", $time, g, e);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	function automatic logic [63:0] wv(input int i);
		return 64'h0123_4567_89AB_CDEF + 64'(i);
	endfunction
	function automatic logic [7:0] lp(input logic [63:0] d);
		logic [7:0] p;
		for (int i = 0; i < 8; i++) begin
			p[i] = ~^8'(d >> (56 - 8 * i));
		end
		return p;
	endfunction
	// One APB transfer, held until pready is seen
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		chk(pready, 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// One tenure answered by the bus model, optional drive disable
	task automatic ten(input logic [3:0] q, input logic [7:0] b, input logic r, t, dis);
		int n;
		n = 0;
		ten_req <= q;
		ten_start <= 1'b1;
		go <= 1'b1;
		burst <= q[2];
		bad <= b;
		rtry <= r;
		transfer_error_ack <= t;
		curw <= q[3];
		wbk = 0;
		@(posedge pclk);
		ten_start <= 1'b0;
		go <= 1'b0;
		data_drive_disable_n <= !dis;
		@(posedge pclk);
		data_drive_disable_n <= 1'b1;
		@(posedge pclk);
		if (dis) chk(data_oe, 1'b0);
		if (dis) chk(data_bus_busy_flag_n_oe, 1'b1);
		while ((ten_busy !== 1'b0 || mb !== 1'b0) && n < 100) begin
			@(posedge pclk);
			n++;
		end
		chk({ten_busy, mb}, 2'b00);
		repeat (2) @(posedge pclk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Pulse counters and driven beat checks
	always @(posedge pclk) begin
		if (rd_valid === 1'b1) begin
			nrd++;
			chk(rd_data, 64'hFEDC_BA98_7654_3210 - 64'(rd_beat));
		end
		nmc += int'(machine_check === 1'b1);
		npe += int'(dpe_n === 1'b0);
		ndone += int'(ten_done === 1'b1);
		if (data_oe === 1'b1) begin
			chk(curw, 1'b1);
			chk(data_out, wv(wbk));
			chk(data_parity_lanes_out, lp(data_out));
		end
		if (transfer_ack_n === 1'b0 && curw === 1'b1) wbk++;
	end
	initial pclk = 1'b0;
	always #20 pclk = ~pclk;
	// Whole run is under 200 cycles, the limit allows ten thousand
	initial begin
		#400000;
		num_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		complete_run;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Test sequence
	initial begin
		{presetn, psel, penable, pwrite, ten_start, wbuf_we, go, burst, rtry, transfer_error_ack, strap} = 11'h0;
		{hard_reset_in_n, data_drive_disable_n, curw} = 3'h6;
		{paddr, pwdata, ten_req, wbuf_addr, wbuf_data, bad} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wbuf_we <= 1'b1;
			wbuf_addr <= 2'(i);
			wbuf_data <= wv(i);
			@(posedge pclk);
		end
		wbuf_we <= 1'b0;
		apb(1'b0, `DTTP_ADDR_CTRL, 32'h0);
		chk(rd, `DTTP_CTRL_RESET);
		apb(1'b0, `DTTP_ADDR_STATUS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, `DTTP_ADDR_STATUS, 32'hFFFF_FFFF);
		apb(1'b0, `DTTP_ADDR_STATUS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h00C, 32'h0);
		chk({perr, rd}, {1'b1, 32'h0});
		$display("test registers done");
		ten(4'b1000, 8'h00, 1'b0, 1'b0, 1'b0);
		ten(4'b1100, 8'h00, 1'b1, 1'b0, 1'b1);
		chk({ndone, nrd}, {32'd2, 32'd0});
		$display("test writes done");
		apb(1'b1, `DTTP_ADDR_CTRL, 32'h3);
		ten(4'b0000, 8'h20, 1'b0, 1'b0, 1'b1);
		chk(nrd, 32'd1);
		chk({npe, nmc}, {32'd1, 32'd1});
		apb(1'b0, `DTTP_ADDR_PERR_CNT, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, `DTTP_ADDR_STATUS, 32'h0);
		chk(rd[15:8], 8'h20);
		ten(4'b0010, 8'h40, 1'b0, 1'b0, 1'b0);
		chk(npe, 32'd1);
		ten(4'b0010, 8'h02, 1'b0, 1'b0, 1'b0);
		chk(npe, 32'd2);
		ten(4'b0100, 8'h00, 1'b1, 1'b0, 1'b0);
		chk(nrd, 32'd7);
		$display("test reads done");
		m = nmc;
		ten(4'b1100, 8'h00, 1'b0, 1'b1, 1'b0);
		chk(nmc, m + 1);
		ten(4'b0010, 8'h00, 1'b0, 1'b1, 1'b0);
		chk(nmc, m + 1);
		apb(1'b0, `DTTP_ADDR_STATUS, 32'h0);
		chk(rd[`DTTP_ST_DEFERRED], 1'b1);
		ten(4'b0011, 8'h00, 1'b0, 1'b1, 1'b0);
		chk(nmc, m + 2);
		apb(1'b1, `DTTP_ADDR_CTRL, 32'h1);
		ten(4'b0000, 8'h00, 1'b0, 1'b1, 1'b0);
		chk(checkstop, 1'b1);
		apb(1'b1, `DTTP_ADDR_CTRL, 32'h2);
		m = npe;
		ten(4'b0000, 8'hFF, 1'b0, 1'b0, 1'b0);
		chk(npe, m);
		$display("test errors done");
		strap <= 1'b1;
		hard_reset_in_n <= 1'b0;
		repeat (3) @(posedge pclk);
		hard_reset_in_n <= 1'b1;
		repeat (3) @(posedge pclk);
		strap <= 1'b0;
		chk(checkstop, 1'b0);
		apb(1'b0, `DTTP_ADDR_STATUS, 32'h0);
		chk(rd[`DTTP_ST_FAST], 1'b1);
		m = nrd;
		ten(4'b0000, 8'h00, 1'b0, 1'b0, 1'b0);
		chk(nrd, m + 1);
		$display("test fast mode done");
		complete_run;
	end
endmodule
